// >>> design/stm_pkg.sv
// Constants, register map and carrier types for the standard timer.
// Assumes a single 100 MHz system clock and an 8-bit register port.
package stm_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned CNT_W         = 16;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned ADDR_W        = 3;

  // Register offsets (byte registers on the plain port)
  localparam logic [2:0] OFS_CTRL0      = 3'h0;
  localparam logic [2:0] OFS_CTRL1      = 3'h1;
  localparam logic [2:0] OFS_CNT_LO     = 3'h2;
  localparam logic [2:0] OFS_CNT_HI     = 3'h3;
  localparam logic [2:0] OFS_CMPA_LO    = 3'h4;
  localparam logic [2:0] OFS_CMPA_HI    = 3'h5;
  localparam logic [2:0] OFS_CMPP       = 3'h6;
  localparam logic [2:0] OFS_FLAGS      = 3'h7;

  // Control-zero field positions
  localparam int unsigned C0_PAUSE_BIT  = 7;
  localparam int unsigned C0_CKSEL_LSB  = 4;
  localparam int unsigned C0_ON_BIT     = 3;
  localparam logic [7:0]  C0_WMASK      = 8'hf8;

  // Flag register bit positions
  localparam int unsigned FLG_A_BIT     = 0;
  localparam int unsigned FLG_P_BIT     = 1;

  // Reset values
  localparam logic [7:0]  RST_CTRL0     = 8'h00;
  localparam logic [7:0]  RST_CTRL1     = 8'h00;
  localparam logic [15:0] RST_CMPA      = 16'h0000;
  localparam logic [7:0]  RST_CMPP      = 8'h00;
  localparam logic [15:0] RST_CNT       = 16'h0000;

  // Timer clock prescale masks (divide by mask plus one)
  localparam logic [7:0]  DIV4_MASK     = 8'h03;
  localparam logic [7:0]  DIV16_MASK    = 8'h0f;
  localparam logic [7:0]  DIV64_MASK    = 8'h3f;
  localparam logic [7:0]  DIVSUB_MASK   = 8'hff;

  // Clock selections
  localparam logic [2:0]  CK_SYS4       = 3'h0;
  localparam logic [2:0]  CK_SYS        = 3'h1;
  localparam logic [2:0]  CK_H16        = 3'h2;
  localparam logic [2:0]  CK_H64        = 3'h3;
  localparam logic [2:0]  CK_SUB0       = 3'h4;
  localparam logic [2:0]  CK_SUB1       = 3'h5;
  localparam logic [2:0]  CK_PIN_RISE   = 3'h6;
  localparam logic [2:0]  CK_PIN_FALL   = 3'h7;

  typedef enum logic [1:0] {
    STM_CMP,
    STM_CAP,
    STM_PWM,
    STM_TMR
  } stm_mode_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] pin_action;
    logic       out_init;
    logic       polarity;
    logic       swap;
    logic       clr_sel;
  } stm_ctl1_t;
endpackage

// >>> design/stm_timer.sv
// Standard 16-bit timer: compare-match output, timer/counter and
// edge-aligned PWM modes with one output pin and two match flags.
// Assumes the register master obeys one-cycle strobes and that the
// external timer clock pin is asynchronous to clk_sys.
`timescale 1ns/1ps
module stm_timer #(
  parameter int unsigned DIV_W = 8
) (
  input  wire logic                         clk_sys,
  input  wire logic                         sys_rst,
  input  wire logic [stm_pkg::ADDR_W-1:0]   bus_addr,
  input  wire logic [stm_pkg::DATA_W-1:0]   bus_wdata,
  input  wire logic                         bus_we,
  input  wire logic                         bus_re,
  output logic      [stm_pkg::DATA_W-1:0]   bus_rdata,
  input  wire logic                         ext_clk_pin,
  output logic                              pin_out,
  output logic                              pin_oe,
  output logic                              match_a_flag,
  output logic                              match_p_flag
);

  logic [7:0]               ctrl0_r;
  stm_pkg::stm_ctl1_t       ctl1_r;
  logic [15:0]              cmpa_r;
  logic [7:0]               cmpp_r;
  logic [15:0]              cnt_r;
  logic [15:0]              cnt_nxt;
  logic                     on_prev_r;
  logic [DIV_W-1:0]         div_r;
  logic                     sync1_r;
  logic                     sync2_r;
  logic                     sync3_r;
  logic                     pin_lvl_r;
  logic                     flag_a_r;
  logic                     flag_p_r;
  logic                     lvl_r;
  logic [7:0]               rdata_r;
  logic                     pin_r;
  logic                     oe_r;

  stm_pkg::stm_mode_t       mode;
  logic                     on_bit;
  logic                     paused;
  logic [2:0]               ck_sel;
  logic                     on_rise;
  logic                     tick;
  logic                     ext_rise;
  logic                     ext_fall;
  logic                     run;
  logic [16:0]              inc;
  logic                     p_hit;
  logic                     a_hit;
  logic                     clr_hit;
  logic                     set_a;
  logic                     set_p;
  logic                     clr_a;
  logic                     clr_p;
  logic                     pwm_act;
  logic                     pwm_lvl;
  logic [7:0]               div8;

  assign mode    = stm_pkg::stm_mode_t'(ctl1_r.mode);
  assign on_bit  = ctrl0_r[stm_pkg::C0_ON_BIT];
  assign paused  = ctrl0_r[stm_pkg::C0_PAUSE_BIT];
  assign ck_sel  = ctrl0_r[stm_pkg::C0_CKSEL_LSB +: 3];
  assign on_rise = on_bit & ~on_prev_r;
  assign div8    = 8'(div_r);

  // Register writes; counter bytes are not writable
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl0_r <= stm_pkg::RST_CTRL0;
      ctl1_r  <= stm_pkg::RST_CTRL1;
      cmpa_r  <= stm_pkg::RST_CMPA;
      cmpp_r  <= stm_pkg::RST_CMPP;
    end else if (bus_we) begin
      unique case (bus_addr)
        stm_pkg::OFS_CTRL0:   ctrl0_r     <= bus_wdata & stm_pkg::C0_WMASK;
        stm_pkg::OFS_CTRL1:   ctl1_r      <= bus_wdata;
        stm_pkg::OFS_CMPA_LO: cmpa_r[7:0] <= bus_wdata;
        stm_pkg::OFS_CMPA_HI: cmpa_r[15:8] <= bus_wdata;
        stm_pkg::OFS_CMPP:    cmpp_r      <= bus_wdata;
        default: ;
      endcase
    end
  end

  // Read port: data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_r <= 8'h00;
    end else if (bus_re) begin
      unique case (bus_addr)
        stm_pkg::OFS_CTRL0:   rdata_r <= ctrl0_r;
        stm_pkg::OFS_CTRL1:   rdata_r <= ctl1_r;
        stm_pkg::OFS_CNT_LO:  rdata_r <= cnt_r[7:0];
        stm_pkg::OFS_CNT_HI:  rdata_r <= cnt_r[15:8];
        stm_pkg::OFS_CMPA_LO: rdata_r <= cmpa_r[7:0];
        stm_pkg::OFS_CMPA_HI: rdata_r <= cmpa_r[15:8];
        stm_pkg::OFS_CMPP:    rdata_r <= cmpp_r;
        stm_pkg::OFS_FLAGS:   rdata_r <= {6'h00, flag_p_r, flag_a_r};
        default:              rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      on_prev_r <= 1'b0;
    end else begin
      on_prev_r <= on_bit;
    end
  end

  // Free-running prescaler shared by the divided internal clock choices; CK_SYS bypasses it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  // Pin clock: first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync1_r   <= 1'b0;
      sync2_r   <= 1'b0;
      sync3_r   <= 1'b0;
      pin_lvl_r <= 1'b0;
    end else begin
      sync1_r <= ext_clk_pin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sync2_r == sync3_r) begin
        pin_lvl_r <= sync3_r;
      end
    end
  end

  assign ext_rise = (sync2_r == sync3_r) & sync3_r & ~pin_lvl_r;
  assign ext_fall = (sync2_r == sync3_r) & ~sync3_r & pin_lvl_r;

  always_comb begin
    unique case (ck_sel)
      stm_pkg::CK_SYS4:     tick = (div8 & stm_pkg::DIV4_MASK) == stm_pkg::DIV4_MASK;
      stm_pkg::CK_SYS:      tick = 1'b1;
      stm_pkg::CK_H16:      tick = (div8 & stm_pkg::DIV16_MASK) == stm_pkg::DIV16_MASK;
      stm_pkg::CK_H64:      tick = (div8 & stm_pkg::DIV64_MASK) == stm_pkg::DIV64_MASK;
      stm_pkg::CK_SUB0,
      stm_pkg::CK_SUB1:     tick = div8 == stm_pkg::DIVSUB_MASK;
      stm_pkg::CK_PIN_RISE: tick = ext_rise;
      stm_pkg::CK_PIN_FALL: tick = ext_fall;
    endcase
  end

  // The cycle of an on-bit rise only clears, so the count starts clean
  assign run = on_bit & ~paused & tick & ~on_rise;
  assign inc = {1'b0, cnt_r} + 17'h00001;

  // P compares the upper byte only, so matches land on 256-count steps
  assign p_hit = run & ((cmpp_r == 8'h00) ? inc[16] :
                        (inc[15:8] == cmpp_r) && (inc[7:0] == 8'h00));
  // A zero compare-A never matches; a count cleared by A simply wraps at FFFF
  assign a_hit = run & (cmpa_r != 16'h0000) & (inc[15:0] == cmpa_r);

  always_comb begin
    unique case (mode)
      stm_pkg::STM_PWM: clr_hit = ctl1_r.swap ? a_hit : p_hit;
      default:          clr_hit = ctl1_r.clr_sel ? a_hit : p_hit;
    endcase
  end

  always_comb begin
    cnt_nxt = cnt_r;
    if (on_rise) begin
      cnt_nxt = stm_pkg::RST_CNT;
    end else if (run) begin
      cnt_nxt = clr_hit ? stm_pkg::RST_CNT : inc[15:0];
    end
  end

  // Counter holds its value while off or paused
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_r <= stm_pkg::RST_CNT;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  always_comb begin
    unique case (mode)
      stm_pkg::STM_PWM: begin
        set_a = a_hit;
        set_p = p_hit;
      end
      stm_pkg::STM_CAP: begin
        set_a = 1'b0;
        set_p = 1'b0;
      end
      default: begin
        set_a = a_hit;
        set_p = p_hit & ~ctl1_r.clr_sel;
      end
    endcase
  end

  assign clr_a = bus_we & (bus_addr == stm_pkg::OFS_FLAGS) & bus_wdata[stm_pkg::FLG_A_BIT];
  assign clr_p = bus_we & (bus_addr == stm_pkg::OFS_FLAGS) & bus_wdata[stm_pkg::FLG_P_BIT];

  // Write-one-to-clear; a match in the clearing cycle still sets
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flag_a_r <= 1'b0;
      flag_p_r <= 1'b0;
    end else begin
      flag_a_r <= set_a | (flag_a_r & ~clr_a);
      flag_p_r <= set_p | (flag_p_r & ~clr_p);
    end
  end

  // Compare-mode level; pin action must differ from the initial level to show
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      lvl_r <= 1'b0;
    end else if (on_rise) begin
      lvl_r <= ctl1_r.out_init;
    end else if (set_a && mode != stm_pkg::STM_PWM) begin
      unique case (ctl1_r.pin_action)
        2'h0: lvl_r <= lvl_r;
        2'h1: lvl_r <= 1'b0;
        2'h2: lvl_r <= 1'b1;
        2'h3: lvl_r <= ~lvl_r;
      endcase
    end
  end

  // Duty at or above period keeps the compare always true
  always_comb begin
    if (ctl1_r.swap) begin
      pwm_act = (cmpp_r == 8'h00) | (cnt_r < {cmpp_r, 8'h00});
    end else begin
      pwm_act = cnt_r < cmpa_r;
    end
  end

  // Forcing the level leaves the counter and flags untouched
  always_comb begin
    unique case (ctl1_r.pin_action)
      2'h0: pwm_lvl = ~ctl1_r.out_init;
      2'h1: pwm_lvl = ctl1_r.out_init;
      2'h2: pwm_lvl = pwm_act ? ctl1_r.out_init : ~ctl1_r.out_init;
      2'h3: pwm_lvl = ~ctl1_r.out_init;
    endcase
  end

  // Capture is not built; the capture and timer settings idle the pin
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_r <= 1'b0;
      oe_r  <= 1'b0;
    end else begin
      unique case (mode)
        stm_pkg::STM_PWM: begin
          pin_r <= pwm_lvl ^ ctl1_r.polarity;
          oe_r  <= 1'b1;
        end
        stm_pkg::STM_CMP: begin
          pin_r <= lvl_r ^ ctl1_r.polarity;
          oe_r  <= 1'b1;
        end
        default: begin
          pin_r <= 1'b0;
          oe_r  <= 1'b0;
        end
      endcase
    end
  end

  assign bus_rdata    = rdata_r;
  assign pin_out      = pin_r;
  assign pin_oe       = oe_r;
  assign match_a_flag = flag_a_r;
  assign match_p_flag = flag_p_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_hi_read;
    bus_re && (bus_addr == stm_pkg::OFS_CNT_HI);
  endsequence

  sequence s_toggle_hit;
    set_a && (mode == stm_pkg::STM_CMP) && (ctl1_r.pin_action == 2'h3) && !on_rise;
  endsequence

  a_cnt_hi_read: assert property (s_hi_read |=> bus_rdata == $past(cnt_r[15:8]))
    else $error("counter high byte read wrong");
  a_on_rise_clear: assert property (on_rise |=> cnt_r == 16'h0000)
    else $error("counter not cleared on enable");
  a_p_clear_flag: assert property ((mode == stm_pkg::STM_CMP) && !ctl1_r.clr_sel
    && p_hit |=> (cnt_r == 16'h0000) && match_p_flag)
    else $error("P match did not clear or flag");
  a_no_p_flag: assert property ((mode != stm_pkg::STM_PWM) && ctl1_r.clr_sel
    && !match_p_flag |=> !match_p_flag)
    else $error("P flag set with A clear select");
  a_a_zero_quiet: assert property ((cmpa_r == 16'h0000) && !match_a_flag
    |=> !match_a_flag)
    else $error("A flag set with zero compare");
  a_tmr_no_drive: assert property ((mode == stm_pkg::STM_TMR) |=> !pin_oe)
    else $error("pin driven in timer mode");
  a_pwm_forced: assert property ((mode == stm_pkg::STM_PWM)
    && (ctl1_r.pin_action == 2'h0)
    |=> pin_out == ($past(~ctl1_r.out_init) ^ $past(ctl1_r.polarity)))
    else $error("forced inactive level wrong");
  a_cmp_toggle: assert property (s_toggle_hit ##1 (mode == stm_pkg::STM_CMP
    && $stable(ctl1_r.polarity) && !on_rise) |=> pin_out != $past(pin_out))
    else $error("toggle action did not toggle pin");
  a_count_step: assert property (run && !clr_hit
    |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("counter did not step by one");
  a_hold_off: assert property (!on_bit && !on_rise |=> $stable(cnt_r))
    else $error("counter moved while off");
  a_a_clear: assert property ((mode inside {stm_pkg::STM_CMP, stm_pkg::STM_TMR})
    && ctl1_r.clr_sel && a_hit |=> (cnt_r == 16'h0000) && match_a_flag)
    else $error("A match did not clear or flag");
  a_a_flag_set: assert property (set_a |=> match_a_flag)
    else $error("A flag not set on match");
  a_p_flag_set: assert property (set_p |=> match_p_flag)
    else $error("P flag not set on match");
  a_p_keeps_pin: assert property ((mode == stm_pkg::STM_CMP) && p_hit && !a_hit
    |=> $stable(lvl_r))
    else $error("P match moved the pin level");
  a_no_action: assert property (set_a && (mode != stm_pkg::STM_PWM)
    && (ctl1_r.pin_action == 2'h0) |=> $stable(lvl_r))
    else $error("pin level moved with no action");
  a_init_level: assert property (on_rise |=> lvl_r == $past(ctl1_r.out_init))
    else $error("initial level not loaded");
  a_pwm_wave: assert property ((mode == stm_pkg::STM_PWM)
    && (ctl1_r.pin_action == 2'h2) |=> pin_out == (($past(pwm_act) ? $past(ctl1_r.out_init)
    : !$past(ctl1_r.out_init)) ^ $past(ctl1_r.polarity)))
    else $error("PWM waveform level wrong");

endmodule // stm_timer

// >>> test/stm_pin_load.sv
// Model of the circuit fed by the timer pin: measures pulse timing.
// Assumes the pin is sampled on clk_sys and reads low while undriven.
`timescale 1ns/1ps
module stm_pin_load (
  input  wire logic        clk_sys,
  input  wire logic        clr,
  input  wire logic        pin,
  input  wire logic        oe,
  output logic      [15:0] rises,
  output logic      [15:0] gap,
  output logic      [15:0] hi_len
);
  logic        lvl;
  logic        lvl_r;
  logic [15:0] since_r;
  logic [15:0] run_r;

  // A released pin is not a valid level, so it never counts as high
  assign lvl = oe & pin;

  always_ff @(posedge clk_sys) begin
    lvl_r   <= lvl;
    since_r <= (lvl && !lvl_r) ? 16'h0000 : since_r + 16'h0001;
    run_r   <= lvl ? run_r + 16'h0001 : 16'h0000;
    if (clr) begin
      rises  <= 16'h0000;
      gap    <= 16'h0000;
      hi_len <= 16'h0000;
    end else begin
      if (lvl && !lvl_r) begin
        rises <= rises + 16'h0001;
        gap   <= since_r + 16'h0001;
      end
      if (!lvl && lvl_r) begin
        hi_len <= run_r;
      end
    end
  end
endmodule // stm_pin_load

// >>> test/tb_standard_timer_compare_pwm.sv
// Self-checking bench for the standard timer: registers, compare and PWM.
// Assumes internal timer clocks only; the external clock pin is held low.
`timescale 1ns/1ps
module tb_standard_timer_compare_pwm;
  logic        clk_sys;
  logic        sys_rst;
  logic [2:0]  bus_addr;
  logic [7:0]  bus_wdata;
  logic        bus_we;
  logic        bus_re;
  logic [7:0]  bus_rdata;
  logic        pin_out;
  logic        pin_oe;
  logic        fa;
  logic        fp;
  logic        clr;
  logic [15:0] rises;
  logic [15:0] gap;
  logic [15:0] hi_len;
  logic [7:0]  d1;
  logic [7:0]  d2;
  int          errors;
  int          checked;
  logic [7:0]  c1s [3];
  logic [15:0] cas [3];
  logic [15:0] e1 [3];
  logic [15:0] e2 [3];

  stm_timer dut_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_we(bus_we), .bus_re(bus_re), .bus_rdata(bus_rdata), .ext_clk_pin(1'b0),
    .pin_out(pin_out), .pin_oe(pin_oe), .match_a_flag(fa), .match_p_flag(fp)
  );
  stm_pin_load u_load (
    .clk_sys(clk_sys), .clr(clr), .pin(pin_out), .oe(pin_oe),
    .rises(rises), .gap(gap), .hi_len(hi_len)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_we    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge clk_sys);
    bus_we <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus_re   <= 1'b1;
    bus_addr <= a;
    @(posedge clk_sys);
    bus_re <= 1'b0;
    #1;
    d = bus_rdata;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Timer is stopped while mode and pin action change, then started
  task automatic cfg(input logic [7:0] c1, input logic [15:0] a, input logic [7:0] p);
    wr(3'h0, 8'h10);
    wr(3'h1, c1);
    wr(3'h4, a[7:0]);
    wr(3'h5, a[15:8]);
    wr(3'h6, p);
    wr(3'h7, 8'h03);
    wr(3'h0, 8'h18);
  endtask

  task automatic meas(input int n);
    @(posedge clk_sys);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #2ms;
    errors++;
    end_sim();
  end

  initial begin
    sys_rst = 1'b1;
    bus_addr = 3'h0;
    bus_wdata = 8'h00;
    bus_we = 1'b0;
    bus_re = 1'b0;
    clr = 1'b0;
    errors = 0;
    checked = 0;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 3; i < 7; i++) begin
      rd(3'(i), d1);
      chk(16'(d1), 16'h0000);
    end
    wr(3'h4, 8'ha5);
    wr(3'h5, 8'h5a);
    wr(3'h6, 8'hc3);
    wr(3'h3, 8'hff);
    rd(3'h4, d1);
    chk(16'(d1), 16'h00a5);
    rd(3'h5, d1);
    chk(16'(d1), 16'h005a);
    rd(3'h6, d1);
    chk(16'(d1), 16'h00c3);
    rd(3'h3, d1);
    chk(16'(d1), 16'h0000);
    // Toggle on A matches only; P clears every 256 counts, then A clears every 320
    cfg(8'h30, 16'h0010, 8'h01);
    repeat (600) @(posedge clk_sys);
    meas(1200);
    chk(gap, 16'd512);
    chk({14'h0, fa, fp}, 16'h0003);
    chk(16'(pin_oe), 16'h0001);
    cfg(8'h31, 16'h0140, 8'h01);
    repeat (600) @(posedge clk_sys);
    meas(1500);
    chk(gap, 16'd640);
    chk({14'h0, fa, fp}, 16'h0002);
    // Mode 11 keeps compare-A zero out of compare mode; P zero runs to overflow
    cfg(8'hf0, 16'h0000, 8'h00);
    meas(65530);
    chk({fa, fp, rises[13:0]}, 16'h0000);
    repeat (10) @(posedge clk_sys);
    #1;
    chk({14'h0, fa, fp}, 16'h0001);
    c1s = '{8'h18, 8'h20, 8'h08};
    e1 = '{16'h1, 16'h0, 16'h1};
    e2 = '{16'h0, 16'h1, 16'h1};
    for (int i = 0; i < 3; i++) begin
      cfg(c1s[i], 16'h0010, 8'h01);
      repeat (4) @(posedge clk_sys);
      #1;
      chk(16'(pin_out), e1[i]);
      repeat (300) @(posedge clk_sys);
      #1;
      chk(16'(pin_out), e2[i]);
    end
    cfg(8'hf0, 16'h0010, 8'h01);
    repeat (600) @(posedge clk_sys);
    #1;
    chk({13'h0, pin_oe, fa, fp}, 16'h0003);
    cfg(8'h40, 16'h0010, 8'h01);
    repeat (600) @(posedge clk_sys);
    #1;
    chk({13'h0, pin_oe, fa, fp}, 16'h0000);
    c1s = '{8'ha8, 8'hac, 8'haa};
    cas = '{16'h0040, 16'h0040, 16'h0200};
    e1 = '{16'd256, 16'd256, 16'd512};
    e2 = '{16'd64, 16'd192, 16'd256};
    for (int i = 0; i < 3; i++) begin
      cfg(c1s[i], cas[i], 8'h01);
      repeat (600) @(posedge clk_sys);
      meas(1100);
      chk(gap, e1[i]);
      chk(hi_len, e2[i]);
      chk({14'h0, fa, fp}, 16'h0003);
    end
    c1s = '{8'h88, 8'h98, 8'ha8};
    cas = '{16'h0040, 16'h0040, 16'h0100};
    e1 = '{16'h0, 16'h1, 16'h1};
    for (int i = 0; i < 3; i++) begin
      cfg(c1s[i], cas[i], 8'h01);
      repeat (300) @(posedge clk_sys);
      meas(600);
      chk({rises[14:0], pin_out}, e1[i]);
      chk(16'(fa), 16'h0001);
    end
    cfg(8'h30, 16'h0010, 8'h10);
    repeat (1000) @(posedge clk_sys);
    wr(3'h0, 8'h10);
    rd(3'h3, d1);
    chk(16'(d1), 16'h0003);
    repeat (50) @(posedge clk_sys);
    rd(3'h3, d2);
    chk(16'(d2), 16'(d1));
    wr(3'h0, 8'h18);
    rd(3'h2, d1);
    chk(16'(d1[7:2]), 16'h0000);
    // Divide-by-four clock: about 300 ticks, so the high byte reads one
    wr(3'h0, 8'h10);
    wr(3'h0, 8'h08);
    repeat (1200) @(posedge clk_sys);
    wr(3'h0, 8'h00);
    rd(3'h3, d1);
    chk(16'(d1), 16'h0001);
    end_sim();
  end
endmodule // tb_standard_timer_compare_pwm
